// File: verilog/scg_pkg.sv
`default_nettype none
package scg_pkg;
  localparam logic [3:0] SCG_CTRL_OFS = 4'h0;
  localparam logic [3:0] SCG_GATE_OFS = 4'h4;
  localparam logic [3:0] SCG_STAT_OFS = 4'h8;
  localparam int SCG_CTRL_MODE_LSB = 0;
  localparam int SCG_CTRL_SE_BIT = 2;
  localparam int SCG_GATE_CONV_BIT = 0;
  localparam int SCG_GATE_SER_BIT = 1;
  localparam int SCG_GATE_T0_BIT = 2;
  localparam int SCG_GATE_T1_BIT = 3;
  localparam logic [2:0] SCG_CTRL_RST = 3'h0;
  localparam logic [3:0] SCG_GATE_RST = 4'h0;
  localparam logic [1:0] SCG_MODE_IDLE = 2'h0;
  localparam logic [1:0] SCG_MODE_NOISE = 2'h1;
  localparam logic [1:0] SCG_MODE_PDOWN = 2'h2;
  localparam logic [1:0] SCG_RESP_OKAY = 2'h0;
  localparam logic [1:0] SCG_RESP_SLVERR = 2'h2;
  localparam int SCG_CLK_NS = 10;
  localparam int SCG_STARTUP_NS = 100;
  localparam int SCG_STARTUP_CYC = (SCG_STARTUP_NS + SCG_CLK_NS - 1) / SCG_CLK_NS;
  localparam int SCG_HALT_CYC = 4;
  localparam logic [7:0] SCG_WAKE_CYC = 8'(SCG_STARTUP_CYC + SCG_HALT_CYC);
  typedef enum logic [2:0] {SCG_ACTIVE, SCG_IDLE, SCG_NOISE, SCG_PDOWN, SCG_WAKE} scg_state_t;
endpackage
`default_nettype wire

// File: verilog/scg_sleep_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module scg_sleep_ctrl
  import scg_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sleep_instr_in,
  input wire logic conv_enable_in,
  input wire logic cmp_enable_in,
  input wire logic cmp_uses_vref_in,
  input wire logic bod_fuse_enable_in,
  input wire logic wdt_enable_in,
  input wire logic external_interrupt_zero_level_mode_in,
  input wire logic external_interrupt_zero_pin_n_in,
  input wire logic pin_change_in,
  input wire logic external_interrupt_zero_edge_irq_in,
  input wire logic conv_done_irq_in,
  input wire logic nvm_ready_irq_in,
  input wire logic serial_start_irq_in,
  input wire logic wdt_irq_in,
  input wire logic other_io_irq_in,
  output logic cpu_clk_en_out,
  output logic flash_clk_en_out,
  output logic io_clk_en_out,
  output logic adc_clk_en_out,
  output logic fast_peripheral_clock_en_out,
  output logic main_osc_en_out,
  output logic timer_one_clk_en_out,
  output logic timer_zero_clk_en_out,
  output logic serial_clk_en_out,
  output logic conv_clk_en_out,
  output logic [3:0] periph_access_en_out,
  output logic cmp_mux_allowed_out,
  output logic conv_start_out,
  output logic conv_extended_out,
  output logic conv_run_out,
  output logic cmp_active_out,
  output logic vref_en_out,
  output logic bod_active_out,
  output logic wdt_active_out,
  output logic input_buf_en_out,
  output logic wake_buf_en_out,
  output logic wake_resume_out
);

  function automatic logic [3:0] scg_reg_sel(input logic [3:0] addr);
    scg_reg_sel = {addr == SCG_STAT_OFS, addr == SCG_GATE_OFS, addr == SCG_CTRL_OFS,
                   addr[1:0] == 2'h0};
  endfunction

  logic [2:0] ctrl_reg;
  logic [3:0] gate_reg;
  logic aw_held_reg;
  logic w_held_reg;
  logic [3:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic [3:0] wsel;
  logic [3:0] rsel;
  logic wr_fire;
  scg_state_t state_reg;
  scg_state_t state_next;
  logic [7:0] wake_cnt_reg;
  logic external_interrupt_zero_meta_reg;
  logic external_interrupt_zero_sync_reg;
  logic pc_meta_reg;
  logic pc_sync_reg;
  logic conv_en_d_reg;
  logic external_interrupt_zero_level_wake;
  logic wake_any;
  logic sleep_go;
  logic [1:0] mode;

  assign mode = ctrl_reg[SCG_CTRL_MODE_LSB +: 2];
  assign wsel = scg_reg_sel(aw_addr_reg);
  assign rsel = scg_reg_sel(s_axi_araddr);
  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;

  // pins pass two flops; only the second stage is looked at
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      external_interrupt_zero_meta_reg <= 1'b1;
      external_interrupt_zero_sync_reg <= 1'b1;
      pc_meta_reg <= 1'b0;
      pc_sync_reg <= 1'b0;
    end
    else
    begin
      external_interrupt_zero_meta_reg <= external_interrupt_zero_pin_n_in;
      external_interrupt_zero_sync_reg <= external_interrupt_zero_meta_reg;
      pc_meta_reg <= pin_change_in;
      pc_sync_reg <= pc_meta_reg;
    end
  end

  // write channels are latched separately so either may arrive first
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 4'h0;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= SCG_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wsel[0] && (wsel[1] || wsel[2])) ? SCG_RESP_OKAY : SCG_RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !aw_held_reg && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !w_held_reg && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  // only the low byte lane carries register bits
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ctrl_reg <= SCG_CTRL_RST;
      gate_reg <= SCG_GATE_RST;
    end
    else if (wr_fire && w_strb_reg[0] && wsel[0])
    begin
      if (wsel[1])
        ctrl_reg <= w_data_reg[2:0];
      if (wsel[2])
        gate_reg <= w_data_reg[3:0];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= SCG_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= SCG_RESP_OKAY;
        s_axi_rdata <= 32'h0;
        if (rsel[0] && rsel[1])
          s_axi_rdata <= {29'h0, ctrl_reg};
        else if (rsel[0] && rsel[2])
          s_axi_rdata <= {28'h0, gate_reg};
        else if (rsel[0] && rsel[3])
          s_axi_rdata <= {21'h0, conv_extended_out, input_buf_en_out, vref_en_out,
                          cmp_active_out, conv_clk_en_out, io_clk_en_out,
                          cpu_clk_en_out, 1'b0, state_reg};
        else
          s_axi_rresp <= SCG_RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // level wake needs the low level seen after synchronising
  assign external_interrupt_zero_level_wake = external_interrupt_zero_level_mode_in && !external_interrupt_zero_sync_reg;
  assign sleep_go = sleep_instr_in && ctrl_reg[SCG_CTRL_SE_BIT];

  always_comb
  begin
    case (state_reg)
      SCG_IDLE:
        wake_any = external_interrupt_zero_level_wake || external_interrupt_zero_edge_irq_in || pc_sync_reg || nvm_ready_irq_in
          || serial_start_irq_in || conv_done_irq_in || other_io_irq_in || wdt_irq_in;
      SCG_NOISE:
        wake_any = conv_done_irq_in || nvm_ready_irq_in || external_interrupt_zero_level_wake || pc_sync_reg
          || serial_start_irq_in || wdt_irq_in;
      SCG_PDOWN:
        wake_any = serial_start_irq_in || external_interrupt_zero_level_wake || pc_sync_reg
          || wdt_irq_in;
      default:
        wake_any = 1'b0;
    endcase
  end

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      SCG_ACTIVE:
        if (sleep_go)
        begin
          case (mode)
            SCG_MODE_IDLE: state_next = SCG_IDLE;
            SCG_MODE_NOISE: state_next = SCG_NOISE;
            SCG_MODE_PDOWN: state_next = SCG_PDOWN;
            default: state_next = SCG_ACTIVE;
          endcase
        end
      SCG_IDLE, SCG_NOISE, SCG_PDOWN:
        if (wake_any)
          state_next = SCG_WAKE;
      SCG_WAKE:
        if (wake_cnt_reg == 8'h1)
          state_next = SCG_ACTIVE;
      default:
        state_next = SCG_ACTIVE;
    endcase
  end

  // the wake count covers start-up plus the four halt cycles
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_reg <= SCG_ACTIVE;
      wake_cnt_reg <= 8'h0;
      wake_resume_out <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      wake_resume_out <= (state_reg == SCG_WAKE) && (state_next == SCG_ACTIVE);
      if (state_next == SCG_WAKE && state_reg != SCG_WAKE)
        wake_cnt_reg <= SCG_WAKE_CYC;
      else if (wake_cnt_reg != 8'h0)
        wake_cnt_reg <= wake_cnt_reg - 8'h1;
    end
  end

  // domain enables follow the next state so they switch with it
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cpu_clk_en_out <= 1'b1;
      flash_clk_en_out <= 1'b1;
      io_clk_en_out <= 1'b1;
      adc_clk_en_out <= 1'b1;
      fast_peripheral_clock_en_out <= 1'b1;
      main_osc_en_out <= 1'b1;
    end
    else
    begin
      cpu_clk_en_out <= state_next == SCG_ACTIVE;
      flash_clk_en_out <= state_next == SCG_ACTIVE;
      io_clk_en_out <= state_next inside {SCG_ACTIVE, SCG_IDLE, SCG_WAKE};
      adc_clk_en_out <= state_next != SCG_PDOWN;
      fast_peripheral_clock_en_out <= state_next inside {SCG_ACTIVE, SCG_IDLE, SCG_WAKE};
      main_osc_en_out <= state_next != SCG_PDOWN;
    end
  end

  // clock gating is and-ed with the io or adc domain, so wherever that domain is off the domain rules; access and mux enables follow gating alone
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      timer_one_clk_en_out <= 1'b1;
      timer_zero_clk_en_out <= 1'b1;
      serial_clk_en_out <= 1'b1;
      conv_clk_en_out <= 1'b1;
      periph_access_en_out <= 4'hf;
      cmp_mux_allowed_out <= 1'b1;
    end
    else
    begin
      timer_one_clk_en_out <= io_clk_en_out && !gate_reg[SCG_GATE_T1_BIT];
      timer_zero_clk_en_out <= io_clk_en_out && !gate_reg[SCG_GATE_T0_BIT];
      serial_clk_en_out <= io_clk_en_out && !gate_reg[SCG_GATE_SER_BIT];
      conv_clk_en_out <= adc_clk_en_out && !gate_reg[SCG_GATE_CONV_BIT];
      periph_access_en_out <= ~gate_reg;
      cmp_mux_allowed_out <= !gate_reg[SCG_GATE_CONV_BIT];
    end
  end

  // analog side: converter, comparator, reference, buffers
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      conv_en_d_reg <= 1'b0;
      conv_start_out <= 1'b0;
      conv_extended_out <= 1'b1;
      conv_run_out <= 1'b0;
      cmp_active_out <= 1'b0;
      vref_en_out <= 1'b0;
      bod_active_out <= 1'b0;
      wdt_active_out <= 1'b0;
      input_buf_en_out <= 1'b1;
      wake_buf_en_out <= 1'b1;
    end
    else
    begin
      conv_en_d_reg <= conv_enable_in;
      conv_start_out <= conv_enable_in && state_reg == SCG_ACTIVE
        && state_next inside {SCG_NOISE, SCG_IDLE};
      if (conv_enable_in && !conv_en_d_reg)
        conv_extended_out <= 1'b1;
      else if (conv_done_irq_in)
        conv_extended_out <= 1'b0;
      conv_run_out <= conv_enable_in;
      cmp_active_out <= cmp_enable_in
        && (state_next != SCG_PDOWN || cmp_uses_vref_in);
      vref_en_out <= bod_fuse_enable_in || conv_enable_in
        || (cmp_enable_in && (state_next != SCG_PDOWN || cmp_uses_vref_in));
      bod_active_out <= bod_fuse_enable_in;
      wdt_active_out <= wdt_enable_in;
      input_buf_en_out <= state_next != SCG_PDOWN;
      wake_buf_en_out <= 1'b1;
    end
  end

  default clocking scg_cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence scg_sleep_req(logic [1:0] m);
    state_reg == SCG_ACTIVE && sleep_go && mode == m;
  endsequence

  noise_entry_a: assert property (scg_sleep_req(SCG_MODE_NOISE)
    |=> state_reg == SCG_NOISE ##1 !io_clk_en_out && adc_clk_en_out)
    else $error("noise entry wrong");
  conv_autostart_a: assert property (scg_sleep_req(SCG_MODE_NOISE)
    && conv_enable_in |=> conv_start_out) else $error("no auto start");
  noise_wake_a: assert property (state_reg == SCG_NOISE && !conv_done_irq_in
    && !nvm_ready_irq_in && !external_interrupt_zero_level_wake && !pc_sync_reg && !serial_start_irq_in
    && !wdt_irq_in |=> state_reg == SCG_NOISE) else $error("bad noise wake");
  pdown_clocks_a: assert property (scg_sleep_req(SCG_MODE_PDOWN) |=> ##1
    !main_osc_en_out && !adc_clk_en_out && !io_clk_en_out) else $error("pdown clocks");
  pdown_wake_a: assert property (state_reg == SCG_PDOWN && !serial_start_irq_in
    && !external_interrupt_zero_level_wake && !pc_sync_reg && !wdt_irq_in |=> state_reg == SCG_PDOWN)
    else $error("bad pdown wake");
  external_interrupt_zero_edge_a: assert property (state_reg == SCG_PDOWN && !external_interrupt_zero_level_mode_in
    && !serial_start_irq_in && !pc_sync_reg && !wdt_irq_in |=> state_reg == SCG_PDOWN)
    else $error("edge external_interrupt_zero woke");
  gate_clock_a: assert property (gate_reg[SCG_GATE_T1_BIT]
    |=> !timer_one_clk_en_out) else $error("timer one not gated");
  gate_read_a: assert property (s_axi_arvalid && s_axi_arready
    && s_axi_araddr == SCG_GATE_OFS |=> s_axi_rdata[31:4] == 28'h0)
    else $error("reserved bits set");
  idle_entry_a: assert property (scg_sleep_req(SCG_MODE_IDLE) |=> ##1
    !cpu_clk_en_out && io_clk_en_out) else $error("idle entry wrong");
  no_enable_a: assert property (state_reg == SCG_ACTIVE && sleep_instr_in
    && !ctrl_reg[SCG_CTRL_SE_BIT] |=> state_reg == SCG_ACTIVE)
    else $error("slept without enable");
  wake_halt_a: assert property (state_reg != SCG_WAKE ##1 state_reg == SCG_WAKE
    |-> ##[1:255] wake_resume_out) else $error("wake never resumed");
  cmp_pdown_a: assert property (state_reg == SCG_PDOWN && !cmp_uses_vref_in
    && $stable(state_reg) |-> !cmp_active_out) else $error("comparator on");
  vref_need_a: assert property (bod_fuse_enable_in |=> vref_en_out)
    else $error("reference off");

endmodule
`default_nettype wire

// File: verification/sleep_and_clock_gating_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define SCG_CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin bad_count++; \
  $display("[FAIL] %0t got %h expected %h", $time, (a), (b)); end end
module sleep_and_clock_gating_control_bench;
  import scg_pkg::*;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  wire logic awready, wready, bvalid, arready, rvalid;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  logic sleep_instr = 1'b0, conv_en = 1'b0, cmp_en = 1'b0, cmp_vref = 1'b0, bod_en = 1'b0;
  logic wdt_en = 1'b0, external_interrupt_zero_lvl = 1'b0, external_interrupt_zero_pin_n = 1'b1, pin_chg = 1'b0, external_interrupt_zero_edge = 1'b0;
  logic conv_done = 1'b0, nvm_rdy = 1'b0, ser_start = 1'b0, wdt_irq = 1'b0, io_irq = 1'b0;
  wire logic cpu_en, flash_en, io_en, adc_en, fast_en, osc_en, t1_en, t0_en, ser_en, cv_en;
  wire logic [3:0] access_en;
  wire logic mux_ok, conv_start, conv_ext, conv_run, cmp_act, vref_en, bod_act, wdt_act;
  wire logic in_buf, wake_buf, resume;
  int bad_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  int n_start = 0;
  int n;
  logic [1:0] resp;
  logic [31:0] rd;

  scg_sleep_ctrl i_scg_sleep_ctrl (
    .clk_in(clk_in), .rst_n_in(rst_n_in),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sleep_instr_in(sleep_instr), .conv_enable_in(conv_en), .cmp_enable_in(cmp_en),
    .cmp_uses_vref_in(cmp_vref), .bod_fuse_enable_in(bod_en), .wdt_enable_in(wdt_en),
    .external_interrupt_zero_level_mode_in(external_interrupt_zero_lvl), .external_interrupt_zero_pin_n_in(external_interrupt_zero_pin_n), .pin_change_in(pin_chg),
    .external_interrupt_zero_edge_irq_in(external_interrupt_zero_edge), .conv_done_irq_in(conv_done), .nvm_ready_irq_in(nvm_rdy),
    .serial_start_irq_in(ser_start), .wdt_irq_in(wdt_irq), .other_io_irq_in(io_irq),
    .cpu_clk_en_out(cpu_en), .flash_clk_en_out(flash_en), .io_clk_en_out(io_en),
    .adc_clk_en_out(adc_en), .fast_peripheral_clock_en_out(fast_en), .main_osc_en_out(osc_en),
    .timer_one_clk_en_out(t1_en), .timer_zero_clk_en_out(t0_en), .serial_clk_en_out(ser_en),
    .conv_clk_en_out(cv_en), .periph_access_en_out(access_en), .cmp_mux_allowed_out(mux_ok),
    .conv_start_out(conv_start), .conv_extended_out(conv_ext), .conv_run_out(conv_run),
    .cmp_active_out(cmp_act), .vref_en_out(vref_en), .bod_active_out(bod_act),
    .wdt_active_out(wdt_act), .input_buf_en_out(in_buf), .wake_buf_en_out(wake_buf),
    .wake_resume_out(resume)
  );

  always #5 clk_in = ~clk_in;

  // pulses are counted at the falling edge, where they are settled
  always @(negedge clk_in)
  begin
    if (conv_start === 1'b1) n_start++;
  end

  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ready is looked at 1 ns after an edge, so it is the value the next edge samples
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_t, w_t, b_t;
    @(posedge clk_in);
    awaddr <= a; wdata <= d; wstrb <= 4'hf; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do
    begin
      #1;
      aw_t = awvalid && awready;
      w_t = wvalid && wready;
      b_t = bvalid;
      r = bresp;
      @(posedge clk_in);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
      if (b_t) bready <= 1'b0;
    end while (!b_t);
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_t, r_t;
    @(posedge clk_in);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do
    begin
      #1;
      ar_t = arvalid && arready;
      r_t = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk_in);
      if (ar_t) arvalid <= 1'b0;
      if (r_t) rready <= 1'b0;
    end while (!r_t);
  endtask

  task automatic do_sleep();
    @(posedge clk_in);
    sleep_instr <= 1'b1;
    @(posedge clk_in);
    sleep_instr <= 1'b0;
    repeat (4) @(posedge clk_in);
    #1;
  endtask

  // cycles from the caller raising a wake source to the resume pulse
  task automatic wait_resume(output int cnt);
    cnt = 0;
    do
    begin
      @(posedge clk_in);
      #1;
      cnt++;
    end while (resume !== 1'b1 && cnt < 200);
  endtask

  initial
  begin
    repeat (6) @(posedge clk_in);
    rst_n_in <= 1'b1;
    axi_rd(SCG_GATE_OFS, rd, resp);
    `SCG_CHK(rd, 32'h0)
    `SCG_CHK(access_en, 4'hf)
    axi_rd(4'hc, rd, resp);
    `SCG_CHK(resp, SCG_RESP_SLVERR)
    // converter and other peripherals are still enabled here, as gating resets to zero
    axi_wr(SCG_GATE_OFS, 32'h0000_00ff, resp);
    `SCG_CHK(resp, SCG_RESP_OKAY)
    axi_rd(SCG_GATE_OFS, rd, resp);
    `SCG_CHK(rd, 32'h0000_000f)
    `SCG_CHK(access_en, 4'h0)
    `SCG_CHK({t1_en, t0_en, ser_en, cv_en, io_en}, 5'b00001)
    `SCG_CHK(mux_ok, 1'b0)
    axi_wr(SCG_GATE_OFS, 32'h0000_0000, resp);
    repeat (2) @(posedge clk_in);
    #1;
    `SCG_CHK({t1_en, t0_en, ser_en, cv_en, mux_ok, access_en}, 9'h1ff)
    // sleep enable still clear: the instruction must do nothing
    axi_wr(SCG_CTRL_OFS, {30'h0, SCG_MODE_PDOWN}, resp);
    do_sleep();
    `SCG_CHK(cpu_en, 1'b1)
    // idle, converter on
    conv_en <= 1'b1;
    axi_wr(SCG_CTRL_OFS, 32'h0000_0004 | SCG_MODE_IDLE, resp);
    n = n_start;
    do_sleep();
    `SCG_CHK({cpu_en, flash_en, io_en, adc_en, fast_en, osc_en}, 6'b001111)
    `SCG_CHK(n_start, n + 1)
    io_irq <= 1'b1;
    wait_resume(n);
    io_irq <= 1'b0;
    `SCG_CHK((n >= SCG_WAKE_CYC) && (n <= SCG_WAKE_CYC + 3), 1'b1)
    `SCG_CHK(cpu_en, 1'b1)
    // noise reduction
    axi_wr(SCG_CTRL_OFS, 32'h0000_0004 | SCG_MODE_NOISE, resp);
    n = n_start;
    do_sleep();
    `SCG_CHK({cpu_en, flash_en, io_en, adc_en, fast_en, osc_en}, 6'b000101)
    `SCG_CHK(n_start, n + 1)
    `SCG_CHK({conv_run, in_buf}, 2'b11)
    io_irq <= 1'b1;
    external_interrupt_zero_edge <= 1'b1;
    repeat (30) @(posedge clk_in);
    #1;
    `SCG_CHK(cpu_en, 1'b0)
    io_irq <= 1'b0;
    external_interrupt_zero_edge <= 1'b0;
    conv_done <= 1'b1;
    wait_resume(n);
    conv_done <= 1'b0;
    `SCG_CHK((n >= SCG_WAKE_CYC) && (n <= SCG_WAKE_CYC + 3), 1'b1)
    `SCG_CHK(conv_ext, 1'b0)
    // power-down with comparator on without the reference
    cmp_en <= 1'b1;
    bod_en <= 1'b1;
    wdt_en <= 1'b1;
    external_interrupt_zero_lvl <= 1'b1;
    axi_wr(SCG_CTRL_OFS, 32'h0000_0004 | SCG_MODE_PDOWN, resp);
    n = n_start;
    do_sleep();
    `SCG_CHK({cpu_en, flash_en, io_en, adc_en, fast_en, osc_en}, 6'b000000)
    `SCG_CHK({in_buf, wake_buf}, 2'b01)
    `SCG_CHK({cmp_act, bod_act, wdt_act, vref_en}, 4'b0111)
    `SCG_CHK(n_start, n)
    axi_rd(SCG_STAT_OFS, rd, resp);
    `SCG_CHK(rd[2:0], 3'h3)
    // pin held low with external_interrupt_zero in edge mode: only the level setting may wake
    conv_done <= 1'b1;
    io_irq <= 1'b1;
    external_interrupt_zero_edge <= 1'b1;
    external_interrupt_zero_lvl <= 1'b0;
    external_interrupt_zero_pin_n <= 1'b0;
    repeat (30) @(posedge clk_in);
    #1;
    `SCG_CHK(cpu_en, 1'b0)
    conv_done <= 1'b0;
    io_irq <= 1'b0;
    external_interrupt_zero_edge <= 1'b0;
    external_interrupt_zero_lvl <= 1'b1;
    wait_resume(n);
    external_interrupt_zero_pin_n <= 1'b1;
    `SCG_CHK((n >= SCG_WAKE_CYC) && (n <= SCG_WAKE_CYC + 6), 1'b1)
    `SCG_CHK(cmp_act, 1'b1)
    // no user of the reference left
    cmp_en <= 1'b0;
    bod_en <= 1'b0;
    conv_en <= 1'b0;
    repeat (4) @(posedge clk_in);
    #1;
    `SCG_CHK(vref_en, 1'b0)
    // converter turned back on: its next conversion is an extended one
    conv_en <= 1'b1;
    repeat (2) @(posedge clk_in);
    #1;
    `SCG_CHK(conv_ext, 1'b1)
    report_and_stop();
  end
endmodule
`default_nettype wire
